//--- tcpu_consts.svh
`ifndef TCPU_CONSTS_SVH
`define TCPU_CONSTS_SVH

// Instance count and widths
`define TCPU_NUM          5
`define TCPU_CW           16
`define TCPU_DW           8

// Per-instance register offsets inside a 32-byte slot
`define TCPU_OFF_CTRL     5'h00
`define TCPU_OFF_PERIOD   5'h04
`define TCPU_OFF_COMPARE  5'h08
`define TCPU_OFF_DEAD     5'h0c
`define TCPU_OFF_CAPT     5'h10
`define TCPU_OFF_COUNT    5'h14

// Shared registers
`define TCPU_ADDR_STATUS  12'h100
`define TCPU_ADDR_MASK    12'h104

// Control fields
`define TCPU_CTRL_W       4
`define TCPU_CTRL_RST     4'h0

// Reset values
`define TCPU_PERIOD_RST   16'hffff
`define TCPU_COMPARE_RST  16'h0000
`define TCPU_DEAD_RST     8'h00

// Status layout: period match in 4:0, capture in 9:5
`define TCPU_ST_W         10
`define TCPU_ST_CAPT      5

`endif

//--- tcpu_pkg.sv
package tcpu_pkg;

    // Per-instance control word
    typedef struct packed {
        logic kill_compl;
        logic kill_true;
        logic oneshot;
        logic enable;
    } tcpu_ctrl_type;

    // Pair of modulated lines
    typedef struct packed {
        logic compl;
        logic line;
    } tcpu_pair_type;

endpackage

//--- tcpu_top.sv
// What this block does
// - Each instance counts with a 16-bit counter whose period is set by software.
// - On a period match the counter halts in one-shot mode or reloads to zero.
// - A capture event from a pin latches the current count for software to read.
// - The count is compared against a programmable value to form the duty cycle.
// - A true and a complementary line are produced, split by a programmable dead band.
// - The shutdown input forces both lines to a set safe level without software.
// - Five independent instances each own counter, period, capture and compare.
//
// Local design decisions: the address map and register access over APB.
`include "tcpu_consts.svh"

module tcpu_top (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    // APB slave
    input  wire logic [11:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // External pins
    input  wire logic [`TCPU_NUM-1:0]   capture_pin,
    input  wire logic                   shutdown_pin,
    // Modulated outputs and interrupt
    output logic      [`TCPU_NUM-1:0]   pwm_line,
    output logic      [`TCPU_NUM-1:0]   pwm_line_compl,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    tcpu_pkg::tcpu_ctrl_type  ctrl_reg    [`TCPU_NUM];
    logic [`TCPU_CW-1:0]      period_reg  [`TCPU_NUM];
    logic [`TCPU_CW-1:0]      compare_reg [`TCPU_NUM];
    logic [`TCPU_DW-1:0]      dead_reg    [`TCPU_NUM];
    logic [`TCPU_CW-1:0]      capt_reg    [`TCPU_NUM];
    logic [`TCPU_CW-1:0]      count_reg   [`TCPU_NUM];
    logic [`TCPU_DW-1:0]      gap_reg     [`TCPU_NUM];
    logic [`TCPU_NUM-1:0]     raw_reg;
    logic [`TCPU_NUM-1:0]     raw_d_reg;
    logic [`TCPU_NUM-1:0]     match_evt;
    logic [`TCPU_NUM-1:0]     capt_evt;
    logic [`TCPU_NUM-1:0]     ctrl_wr;
    logic [`TCPU_NUM-1:0]     line_reg;
    logic [`TCPU_NUM-1:0]     compl_reg;
    logic [`TCPU_ST_W-1:0]    status_reg;
    logic [`TCPU_ST_W-1:0]    status_next;
    logic [`TCPU_ST_W-1:0]    mask_reg;
    logic [31:0]              prdata_reg;
    logic                     pready_reg;
    logic                     pslverr_reg;
    logic                     irq_reg;
    logic                     bus_wr;
    logic [`TCPU_NUM:0]       sync1_reg;
    logic [`TCPU_NUM:0]       sync2_reg;
    logic [`TCPU_NUM:0]       sync3_reg;
    logic [`TCPU_NUM:0]       filt_reg;
    logic [`TCPU_NUM:0]       agree;
    logic                     kill_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // True when addr hits register off of instance idx
    function automatic logic inst_hit(input logic [11:0] addr,
                                      input int          idx,
                                      input logic [4:0]  off);
        inst_hit = (addr[11:8] == 4'h0) && (addr[7:5] == 3'(idx))
                   && (addr[4:0] == off);
    endfunction

    // True when addr is any mapped register
    function automatic logic mapped(input logic [11:0] addr);
        logic ok;
        ok = (addr == `TCPU_ADDR_STATUS) || (addr == `TCPU_ADDR_MASK);
        for (int k = 0; k < `TCPU_NUM; k++)
        begin
            ok = ok || (addr[11:8] == 4'h0 && addr[7:5] == 3'(k)
                        && addr[4:0] <= `TCPU_OFF_COUNT
                        && addr[1:0] == 2'h0);
        end
        mapped = ok;
    endfunction

    // Read mux
    function automatic logic [31:0] read_word(input logic [11:0] addr);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (addr == `TCPU_ADDR_STATUS)
            d = 32'(status_reg);
        if (addr == `TCPU_ADDR_MASK)
            d = 32'(mask_reg);
        for (int k = 0; k < `TCPU_NUM; k++)
        begin
            if (inst_hit(addr, k, `TCPU_OFF_CTRL))
                d = 32'(ctrl_reg[k]);
            if (inst_hit(addr, k, `TCPU_OFF_PERIOD))
                d = 32'(period_reg[k]);
            if (inst_hit(addr, k, `TCPU_OFF_COMPARE))
                d = 32'(compare_reg[k]);
            if (inst_hit(addr, k, `TCPU_OFF_DEAD))
                d = 32'(dead_reg[k]);
            if (inst_hit(addr, k, `TCPU_OFF_CAPT))
                d = 32'(capt_reg[k]);
            if (inst_hit(addr, k, `TCPU_OFF_COUNT))
                d = 32'(count_reg[k]);
        end
        read_word = d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one access cycle, data and error prepared in setup

    assign bus_wr = psel & penable & pready_reg & pwrite;

    // Ready in the access phase only
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            pready_reg <= 1'b0;
        else
            pready_reg <= psel & ~penable;
    end

    // Read data and error for unmapped addresses
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : read_word(paddr);
            pslverr_reg <= ~mapped(paddr);
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when 2 and 3 agree

    assign agree = ~(sync2_reg ^ sync3_reg);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg  <= '0;
        end
        else
        begin
            sync1_reg <= {shutdown_pin, capture_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= (sync2_reg & agree) | (filt_reg & ~agree);
        end
    end

    assign capt_evt = sync2_reg[`TCPU_NUM-1:0] & agree[`TCPU_NUM-1:0]
                      & ~filt_reg[`TCPU_NUM-1:0];
    assign kill_reg = filt_reg[`TCPU_NUM];

    ////////////////////////////////////////////////////////////////////////
    // Instances

    genvar g;
    generate
        for (g = 0; g < `TCPU_NUM; g++)
        begin : g_inst
            assign ctrl_wr[g]   = bus_wr
                                  & inst_hit(paddr, g, `TCPU_OFF_CTRL);
            assign match_evt[g] = ctrl_reg[g].enable
                                  & (count_reg[g] == period_reg[g]);

            // Setup registers; one-shot halt drops enable
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                    ctrl_reg[g] <= `TCPU_CTRL_RST;
                else if (ctrl_wr[g])
                    ctrl_reg[g] <= pwdata[`TCPU_CTRL_W-1:0];
                else if (match_evt[g] & ctrl_reg[g].oneshot)
                    ctrl_reg[g].enable <= 1'b0;
            end

            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    period_reg[g]  <= `TCPU_PERIOD_RST;
                    compare_reg[g] <= `TCPU_COMPARE_RST;
                    dead_reg[g]    <= `TCPU_DEAD_RST;
                end
                else if (bus_wr)
                begin
                    if (inst_hit(paddr, g, `TCPU_OFF_PERIOD))
                        period_reg[g] <= pwdata[`TCPU_CW-1:0];
                    if (inst_hit(paddr, g, `TCPU_OFF_COMPARE))
                        compare_reg[g] <= pwdata[`TCPU_CW-1:0];
                    if (inst_hit(paddr, g, `TCPU_OFF_DEAD))
                        dead_reg[g] <= pwdata[`TCPU_DW-1:0];
                end
            end

            // Counter: restart on enable write, reload or halt on match
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                    count_reg[g] <= '0;
                else if (ctrl_wr[g] & pwdata[0] & ~ctrl_reg[g].enable)
                    count_reg[g] <= '0;
                else if (match_evt[g])
                begin
                    if (!ctrl_reg[g].oneshot)
                        count_reg[g] <= '0;
                end
                else if (ctrl_reg[g].enable)
                    count_reg[g] <= count_reg[g] + 16'h0001;
            end

            // Capture latch
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                    capt_reg[g] <= '0;
                else if (capt_evt[g])
                    capt_reg[g] <= count_reg[g];
            end

            // Duty compare and dead-band gap counter
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    raw_reg[g]   <= 1'b0;
                    raw_d_reg[g] <= 1'b0;
                    gap_reg[g]   <= '0;
                end
                else
                begin
                    raw_reg[g]   <= count_reg[g] < compare_reg[g];
                    raw_d_reg[g] <= raw_reg[g];
                    if (raw_reg[g] != raw_d_reg[g] && dead_reg[g] != '0)
                        gap_reg[g] <= dead_reg[g] - 8'h01;
                    else if (gap_reg[g] != '0)
                        gap_reg[g] <= gap_reg[g] - 8'h01;
                end
            end

            // Output pair, shutdown level has priority
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    line_reg[g]  <= 1'b0;
                    compl_reg[g] <= 1'b0;
                end
                else if (kill_reg)
                begin
                    line_reg[g]  <= ctrl_reg[g].kill_true;
                    compl_reg[g] <= ctrl_reg[g].kill_compl;
                end
                else if ((raw_reg[g] != raw_d_reg[g] && dead_reg[g] != '0)
                         || gap_reg[g] != '0)
                begin
                    line_reg[g]  <= 1'b0;
                    compl_reg[g] <= 1'b0;
                end
                else
                begin
                    line_reg[g]  <= raw_reg[g];
                    compl_reg[g] <= ~raw_reg[g];
                end
            end
        end
    endgenerate

    assign pwm_line       = line_reg;
    assign pwm_line_compl = compl_reg;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status (write one to clear, set wins), mask, output

    always_comb
    begin
        status_next = status_reg;
        if (bus_wr && paddr == `TCPU_ADDR_STATUS)
            status_next = status_next & ~pwdata[`TCPU_ST_W-1:0];
        status_next = status_next | {capt_evt, match_evt};
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            status_reg <= '0;
        else
            status_reg <= status_next;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            mask_reg <= '0;
        else if (bus_wr && paddr == `TCPU_ADDR_MASK)
            mask_reg <= pwdata[`TCPU_ST_W-1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(status_reg & mask_reg);
    end

    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_pin_held;
        shutdown_pin [*4];
    endsequence

    property p_kill_seen;
        s_pin_held |=> kill_reg;
    endproperty
    a_kill_seen: assert property (p_kill_seen)
        else $error("Shutdown not recognised in four cycles");

    generate
        for (g = 0; g < `TCPU_NUM; g++)
        begin : g_chk
            property p_count_adv;
                ctrl_reg[g].enable && !match_evt[g] && !ctrl_wr[g]
                |=> count_reg[g] == $past(count_reg[g]) + 16'h0001;
            endproperty
            a_count_adv: assert property (p_count_adv)
                else $error("Enabled counter did not advance");

            property p_count_hold;
                !ctrl_reg[g].enable && !ctrl_wr[g] |=> $stable(count_reg[g]);
            endproperty
            a_count_hold: assert property (p_count_hold)
                else $error("Disabled counter moved");

            property p_reload;
                match_evt[g] && !ctrl_reg[g].oneshot && !ctrl_wr[g]
                |=> count_reg[g] == 16'h0000 ##1 count_reg[g] == 16'h0001;
            endproperty
            a_reload: assert property (p_reload)
                else $error("Counter did not reload after match");

            property p_halt;
                match_evt[g] && ctrl_reg[g].oneshot && !ctrl_wr[g]
                |=> !ctrl_reg[g].enable
                    && count_reg[g] == $past(period_reg[g]);
            endproperty
            a_halt: assert property (p_halt)
                else $error("One-shot counter did not halt");

            property p_capture;
                capt_evt[g] |=> capt_reg[g] == $past(count_reg[g])
                                && status_reg[`TCPU_ST_CAPT + g];
            endproperty
            a_capture: assert property (p_capture)
                else $error("Capture did not latch the count");

            // With no dead band the line follows raw one cycle later
            property p_duty;
                !kill_reg && !$past(kill_reg) && line_reg[g]
                |-> $past(raw_reg[g])
                    && ($past(raw_reg[g], 2) || $past(dead_reg[g]) == 8'h00);
            endproperty
            a_duty: assert property (p_duty)
                else $error("True line high outside compare window");

            property p_excl;
                !$past(kill_reg) |-> !(line_reg[g] && compl_reg[g]);
            endproperty
            a_excl: assert property (p_excl)
                else $error("True and complement high together");

            // A raw edge with a dead band opens a gap on both lines
            sequence s_raw_edge;
                raw_reg[g] != raw_d_reg[g] && dead_reg[g] != 8'h00
                && !kill_reg;
            endsequence

            property p_gap;
                s_raw_edge |=> !line_reg[g] && !compl_reg[g];
            endproperty
            a_gap: assert property (p_gap)
                else $error("No dead-band gap after a duty edge");

            property p_kill_level;
                kill_reg |=> line_reg[g] == $past(ctrl_reg[g].kill_true)
                         && compl_reg[g] == $past(ctrl_reg[g].kill_compl);
            endproperty
            a_kill_level: assert property (p_kill_level)
                else $error("Outputs not at shutdown level");
        end
    endgenerate

endmodule

//--- tcpu_load_model.sv
`include "tcpu_consts.svh"

module tcpu_load_model #(
    parameter int IDX = 2
) (
    // Clock and window clear
    input  wire logic                 sys_clk,
    input  wire logic                 count_clr,
    // Modulated lines from the block
    input  wire logic [`TCPU_NUM-1:0] pwm_line,
    input  wire logic [`TCPU_NUM-1:0] pwm_line_compl,
    // Conduction counts of the watched switch pair
    output logic      [15:0]          line_cnt,
    output logic      [15:0]          compl_cnt,
    output logic      [15:0]          both_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    //////////////////////////////////////////////////////////////////////////
    // Counts on-cycles of each leg; both legs on at once would short the rail
    always_ff @(posedge sys_clk)
    begin
        if (count_clr)
        begin
            line_cnt  <= 16'h0000;
            compl_cnt <= 16'h0000;
            both_cnt  <= 16'h0000;
        end
        else
        begin
            line_cnt  <= line_cnt + 16'(pwm_line[IDX]);
            compl_cnt <= compl_cnt + 16'(pwm_line_compl[IDX]);
            both_cnt  <= both_cnt + 16'(pwm_line[IDX] & pwm_line_compl[IDX]);
        end
    end
endmodule

//--- timer_counter_pwm_unit_tb.sv
`include "tcpu_consts.svh"

module timer_counter_pwm_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // One table row: access, expected data and error flag
    typedef struct {
        logic        w;
        logic [11:0] addr;
        logic [31:0] d;
        logic [31:0] exp;
        logic        err;
    } tcpu_row_type;

    logic                  sys_clk      = 1'b0;
    logic                  sys_rst      = 1'b1;
    logic [11:0]           paddr        = 12'h000;
    logic                  psel         = 1'b0;
    logic                  penable      = 1'b0;
    logic                  pwrite       = 1'b0;
    logic [31:0]           pwdata       = 32'h0;
    logic [`TCPU_NUM-1:0]  capture_pin  = 5'h00;
    logic                  shutdown_pin = 1'b0;
    logic                  count_clr    = 1'b0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic [`TCPU_NUM-1:0]  pwm_line;
    logic [`TCPU_NUM-1:0]  pwm_line_compl;
    logic [15:0]           line_cnt;
    logic [15:0]           compl_cnt;
    logic [15:0]           both_cnt;
    logic [31:0]           rdat;
    logic [31:0]           cnt;
    logic                  rerr;
    int                    errors       = 0;
    int                    checks_done  = 0;
    tcpu_row_type          rows [14];
    tcpu_pkg::tcpu_ctrl_type kill_cv    = '{1'b1, 1'b1, 1'b0, 1'b1};

    //////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #2 sys_clk = ~sys_clk;

    tcpu_top dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_pin(capture_pin), .shutdown_pin(shutdown_pin),
        .pwm_line(pwm_line), .pwm_line_compl(pwm_line_compl), .irq(irq)
    );

    tcpu_load_model #(.IDX(2)) load (
        .sys_clk(sys_clk), .count_clr(count_clr), .pwm_line(pwm_line),
        .pwm_line_compl(pwm_line_compl), .line_cnt(line_cnt),
        .compl_cnt(compl_cnt), .both_cnt(both_cnt)
    );

    //////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Setup cycle, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1 && n++ < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            $display("ERROR pready expected 1 seen %b", pready);
        end
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        tick(6000);
        errors++;
        finish_test;
    end

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rows = '{
            '{0, 12'h000, 32'h0, 32'h0, 0}, '{0, 12'h004, 32'h0, 32'hffff, 0},
            '{0, 12'h008, 32'h0, 32'h0, 0}, '{0, 12'h00c, 32'h0, 32'h0, 0},
            '{0, 12'h010, 32'h0, 32'h0, 0}, '{0, 12'h014, 32'h0, 32'h0, 0},
            '{0, 12'h100, 32'h0, 32'h0, 0}, '{0, 12'h104, 32'h0, 32'h0, 0},
            '{0, 12'h018, 32'h0, 32'h0, 1}, '{0, 12'h0a0, 32'h0, 32'h0, 1},
            '{0, 12'h102, 32'h0, 32'h0, 1}, '{1, 12'h018, 32'hffff, 32'h0, 1},
            '{1, 12'h084, 32'h11234, 32'h0, 0},
            '{0, 12'h084, 32'h0, 32'h1234, 0}};
        tick(10);
        sys_rst <= 1'b0;
        chk("irq_rst", 32'h0, 32'(irq));
        // Table: per-instance rows repeat over all five slots
        foreach (rows[i])
            for (int n = 0; n < (rows[i].addr < 12'h020 ? 5 : 1); n++)
            begin
                apb(rows[i].w, rows[i].addr + 12'(n * 32), rows[i].d);
                if (!rows[i].w)
                    chk("rd_data", rows[i].exp, rdat);
                chk("rd_err", 32'(rows[i].err), 32'(rerr));
            end
        // Instance 0 reloads at period 5
        wr(12'h004, 32'h5);
        wr(12'h000, 32'h1);
        cnt = 32'hffff_ffff;
        repeat (5)
        begin
            rd(12'h014);
            chk("reload_range", 32'h1, 32'(rdat <= 32'h5));
            chk("reload_moves", 32'h1, 32'(rdat != cnt));
            cnt = rdat;
        end
        // Instance 1 one-shot halts at period and holds
        wr(12'h024, 32'h14);
        wr(12'h020, 32'h3);
        tick(40);
        rd(12'h034);
        chk("oneshot_count", 32'h14, rdat);
        rd(12'h020);
        chk("oneshot_ctrl", 32'h2, rdat);
        tick(10);
        rd(12'h034);
        chk("hold_count", 32'h14, rdat);
        // Instance 3 steps by one per clock, then captures on a pin edge
        wr(12'h060, 32'h1);
        rd(12'h074);
        cnt = rdat;
        rd(12'h074);
        chk("count_step", 32'h3, rdat - cnt);
        @(posedge sys_clk);
        capture_pin[3] <= 1'b1;
        tick(10);
        rd(12'h070);
        cnt = rdat;
        rd(12'h074);
        chk("capt_range", 32'h1, 32'(cnt > 32'h3 && cnt < rdat));
        // Status, mask and interrupt
        rd(12'h100);
        chk("status_set", 32'h103, rdat & 32'h103);
        chk("irq_masked", 32'h0, 32'(irq));
        wr(12'h104, 32'h100);
        tick(3);
        chk("irq_on", 32'h1, 32'(irq));
        wr(12'h000, 32'h0);
        wr(12'h100, 32'h3ff);
        tick(3);
        chk("irq_off", 32'h0, 32'(irq));
        rd(12'h100);
        chk("status_clr", 32'h0, rdat & 32'h103);
        // Instance 2 duty and dead band, measured at the load
        wr(12'h044, 32'h9);
        wr(12'h048, 32'h4);
        for (int d = 0; d < 3; d += 2)
        begin
            wr(12'h04c, 32'(d));
            wr(12'h040, 32'h1);
            tick(20);
            count_clr <= 1'b1;
            tick(1);
            count_clr <= 1'b0;
            tick(100);
            #1;
            chk("line_on", 32'(40 - 10 * d), 32'(line_cnt));
            chk("compl_on", 32'(60 - 10 * d), 32'(compl_cnt));
            chk("overlap", 32'h0, 32'(both_cnt));
        end
        // Shutdown forces the programmed kill levels
        wr(12'h040, 32'(kill_cv));
        shutdown_pin <= 1'b1;
        tick(8);
        chk("kill_line", 32'h4, 32'(pwm_line));
        chk("kill_compl", 32'h4, 32'(pwm_line_compl));
        shutdown_pin <= 1'b0;
        tick(8);
        chk("kill_release", 32'h1, 32'(pwm_line_compl[0]));
        // Second reset in mid-run
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        rd(12'h044);
        chk("rst_again", 32'hffff, rdat);
        finish_test;
    end
endmodule
